// ---- inc/spc_defs.vh ----
// Constants for the synthesizer configuration and test pin block
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// Register indices (word addresses on the plain port)
`define SPC_ADDR_W        4
`define SPC_A_CTRL        4'h0
`define SPC_A_MOD         4'h1
`define SPC_A_STAT        4'h2
`define SPC_A_LDCNT       4'h3

// Control word fields (index 0)
`define SPC_B_XO          0
`define SPC_F_CPG_LO      1
`define SPC_F_CPG_HI      5
`define SPC_F_SEL_LO      6
`define SPC_F_SEL_HI      9
`define SPC_B_CPP         10
`define SPC_B_DBL         11
`define SPC_B_CPT         12

// Modulator word fields (index 1)
`define SPC_B_FDM         0
`define SPC_F_ORD_LO      1
`define SPC_F_ORD_HI      3
`define SPC_F_DITHER_STRENGTH_LO     4
`define SPC_F_DITHER_STRENGTH_HI     5

// Reset values
`define SPC_CTRL_RST      32'h0000_0000
`define SPC_MOD_RST       32'h0000_0037

// Test pin selector codes
`define SPC_SEL_HIZ       4'h0
`define SPC_SEL_HIGH      4'h1
`define SPC_SEL_LOW       4'h2
`define SPC_SEL_DLD_PP    4'h3
`define SPC_SEL_DLD_INV   4'h4
`define SPC_SEL_DLD_OD    4'h5
`define SPC_SEL_ALD_OD    4'h6
`define SPC_SEL_ALD_PP    4'h7
`define SPC_SEL_NDIV      4'h8
`define SPC_SEL_NDIV2     4'h9
`define SPC_SEL_RDIV      4'hA
`define SPC_SEL_RDIV2     4'hB
`define SPC_SEL_UP        4'hC
`define SPC_SEL_DN        4'hD

// Modulator order and dither codes
`define SPC_ORD_INT       3'h0
`define SPC_ORD_FIRST     3'h1
`define SPC_ORD_MAX       3'h4
`define SPC_DITHER_STRENGTH_OFF      2'h3

// Lock detect: consecutive in-window cycles needed
`define SPC_LOCK_CYCLES   3'h5
`define SPC_LOCK_CNT_W    3

// Fractional word masks
`define SPC_FRAC_W        22
`define SPC_FRAC_MASK10   22'h0003FF
`define SPC_FRAC_MASK22   22'h3FFFFF

`endif

// ---- hdl/spc_config_test_mux.v ----
// Configuration register bank, lock detect and test pin multiplexer
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`include "spc_defs.vh"

module spc_config_test_mux #(
  parameter LOCK_CYCLES = `SPC_LOCK_CYCLES
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire [3:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  input  wire        i_pd_tick,
  input  wire        i_in_window,
  input  wire        i_analog_lock,
  input  wire        i_ndiv_pulse,
  input  wire        i_rdiv_pulse,
  input  wire        i_pd_up,
  input  wire        i_pd_dn,
  input  wire [21:0] i_frac_num,
  input  wire [21:0] i_frac_den,
  output reg         o_osc_amp_en,
  output reg  [5:0]  o_pump_steps,
  output reg         o_pump_positive,
  output reg         o_pump_high_z,
  output reg         o_ref_double,
  output reg         o_rdiv_bypass,
  output reg  [21:0] o_frac_num,
  output reg  [21:0] o_frac_den,
  output reg         o_mod_enable,
  output reg  [2:0]  o_mod_order,
  output reg         o_mod_illegal,
  output reg         o_analog_comp_en,
  output reg         o_dither_en,
  output reg  [1:0]  o_dither_level,
  output reg         o_wide_n_count,
  output reg         o_lock,
  output reg         o_pin_out,
  output reg         o_pin_oe
);

  // Reset release through two flops
  reg rst_s1_reg;
  reg rst_reg;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_reg    <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_reg    <= rst_s1_reg;
    end
  end
  wire rst_n = rst_reg;

  // Word 0: [0] crystal amp, [5:1] pump gain, [9:6] pin select,
  //         [10] pump polarity, [11] doubler, [12] pump float
  // Word 1: [0] extended fraction, [3:1] order, [5:4] dither
  // Word 2 is read-only status, word 3 the read-only lock counter
  // Field registers; a whole word lands in one edge, so no half update
  reg [31:0] ctrl_reg;
  reg [31:0] mod_reg;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `SPC_CTRL_RST;
      mod_reg  <= `SPC_MOD_RST;
    end else if (i_wr) begin
      if (i_addr == `SPC_A_CTRL)
        ctrl_reg <= i_wdata;
      if (i_addr == `SPC_A_MOD)
        mod_reg <= i_wdata;
    end
  end

  wire [4:0] cpg_f  = ctrl_reg[`SPC_F_CPG_HI:`SPC_F_CPG_LO];
  wire [3:0] sel_f  = ctrl_reg[`SPC_F_SEL_HI:`SPC_F_SEL_LO];
  wire [2:0] ord_f  = mod_reg[`SPC_F_ORD_HI:`SPC_F_ORD_LO];
  wire [1:0] dither_strength_f = mod_reg[`SPC_F_DITHER_STRENGTH_HI:`SPC_F_DITHER_STRENGTH_LO];

  // Applies the 10-bit or 22-bit fractional mask
  function [21:0] frac_sel;
    input [21:0] v;
    input        wide;
    begin
      frac_sel = v & (wide ? `SPC_FRAC_MASK22 : `SPC_FRAC_MASK10);
    end
  endfunction

  // Orders above the fourth are illegal and act as integer mode
  function ord_legal;
    input [2:0] o;
    begin
      ord_legal = (o <= `SPC_ORD_MAX);
    end
  endfunction

  // Only second to fourth order carry compensation and dither
  function ord_shaped;
    input [2:0] o;
    begin
      ord_shaped = (o > `SPC_ORD_FIRST) && (o <= `SPC_ORD_MAX);
    end
  endfunction

  // Rising edge of a synchronised level against its delayed copy
  function edge_up;
    input cur;
    input prev;
    begin
      edge_up = cur & ~prev;
    end
  endfunction

  // Decoded analog and modulator controls, all from flops
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_osc_amp_en     <= 1'b0;
      o_pump_steps     <= 6'h01;
      o_pump_positive  <= 1'b0;
      o_pump_high_z    <= 1'b0;
      o_ref_double     <= 1'b0;
      o_rdiv_bypass    <= 1'b0;
      o_frac_num       <= 22'h000000;
      o_frac_den       <= 22'h000000;
      o_mod_enable     <= 1'b0;
      o_mod_order      <= 3'h0;
      o_mod_illegal    <= 1'b0;
      o_analog_comp_en <= 1'b0;
      o_dither_en      <= 1'b0;
      o_dither_level   <= 2'h0;
      o_wide_n_count   <= 1'b1;
    end else begin
      o_osc_amp_en    <= ctrl_reg[`SPC_B_XO];
      o_pump_steps    <= {1'b0, cpg_f} + 6'h01;
      o_pump_positive <= ctrl_reg[`SPC_B_CPP];
      o_pump_high_z   <= ctrl_reg[`SPC_B_CPT];
      o_ref_double    <= ctrl_reg[`SPC_B_DBL];
      o_rdiv_bypass   <= ctrl_reg[`SPC_B_DBL];
      o_frac_num <= frac_sel(i_frac_num, mod_reg[`SPC_B_FDM]);
      o_frac_den <= frac_sel(i_frac_den, mod_reg[`SPC_B_FDM]);
      // Illegal orders fall back to integer mode rather than run wild
      o_mod_illegal  <= !ord_legal(ord_f);
      o_mod_enable   <= (ord_f != `SPC_ORD_INT) &&
                        ord_legal(ord_f);
      o_mod_order    <= ord_legal(ord_f) ? ord_f : `SPC_ORD_INT;
      o_wide_n_count <= (ord_f == `SPC_ORD_INT) ||
                        !ord_legal(ord_f);
      o_analog_comp_en <= ord_shaped(ord_f);
      // Dither never reaches a first order or integer loop
      o_dither_en <= (dither_strength_f != `SPC_DITHER_STRENGTH_OFF) &&
                     ord_shaped(ord_f);
      o_dither_level <= dither_strength_f;
    end
  end

  // Synchronise the pin-side inputs
  reg [6:0] in_s1_reg;
  reg [6:0] in_s2_reg;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_reg <= 7'h00;
      in_s2_reg <= 7'h00;
    end else begin
      in_s1_reg <= {i_pd_tick, i_in_window, i_analog_lock, i_ndiv_pulse,
                    i_rdiv_pulse, i_pd_up, i_pd_dn};
      in_s2_reg <= in_s1_reg;
    end
  end
  wire pd_tick_s = in_s2_reg[6];
  wire in_win_s  = in_s2_reg[5];
  wire ald_s     = in_s2_reg[4];
  wire ndiv_s    = in_s2_reg[3];
  wire rdiv_s    = in_s2_reg[2];
  wire up_s      = in_s2_reg[1];
  wire dn_s      = in_s2_reg[0];

  // Edge detect on synchronised copies only
  reg tick_d_reg;
  reg ndiv_d_reg;
  reg rdiv_d_reg;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_d_reg <= 1'b0;
      ndiv_d_reg <= 1'b0;
      rdiv_d_reg <= 1'b0;
    end else begin
      tick_d_reg <= pd_tick_s;
      ndiv_d_reg <= ndiv_s;
      rdiv_d_reg <= rdiv_s;
    end
  end
  wire tick_rise = edge_up(pd_tick_s, tick_d_reg);

  // Lock counter: one count per phase detector cycle in window
  reg [`SPC_LOCK_CNT_W-1:0] lock_cnt_reg;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_reg <= {`SPC_LOCK_CNT_W{1'b0}};
      o_lock       <= 1'b0;
    end else if (tick_rise) begin
      if (!in_win_s) begin
        lock_cnt_reg <= {`SPC_LOCK_CNT_W{1'b0}};
        o_lock       <= 1'b0;
      end else if (lock_cnt_reg ==
                   LOCK_CYCLES[`SPC_LOCK_CNT_W-1:0] - 3'h1) begin
        o_lock <= 1'b1;
      end else begin
        lock_cnt_reg <= lock_cnt_reg + 3'h1;
      end
    end
  end

  // Halved diagnostics toggle once per source pulse for even duty
  reg ndiv_half_reg;
  reg rdiv_half_reg;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ndiv_half_reg <= 1'b0;
      rdiv_half_reg <= 1'b0;
    end else begin
      if (edge_up(ndiv_s, ndiv_d_reg))
        ndiv_half_reg <= ~ndiv_half_reg;
      if (edge_up(rdiv_s, rdiv_d_reg))
        rdiv_half_reg <= ~rdiv_half_reg;
    end
  end

  // Test pin multiplexer; open drain drives only the low level
  reg pin_nx;
  reg oe_nx;
  always @* begin
    pin_nx = 1'b0;
    oe_nx  = 1'b1;
    case (sel_f)
      `SPC_SEL_HIZ: begin
        pin_nx = 1'b0;
        oe_nx  = 1'b0;
      end
      `SPC_SEL_HIGH: begin
        pin_nx = 1'b1;
        oe_nx  = 1'b1;
      end
      `SPC_SEL_LOW: begin
        pin_nx = 1'b0;
        oe_nx  = 1'b1;
      end
      `SPC_SEL_DLD_PP: begin
        pin_nx = o_lock;
        oe_nx  = 1'b1;
      end
      `SPC_SEL_DLD_INV: begin
        pin_nx = ~o_lock;
        oe_nx  = 1'b1;
      end
      // Open drain pulls low while unlocked; the pull-up shows lock
      `SPC_SEL_DLD_OD: begin
        pin_nx = 1'b0;
        oe_nx  = ~o_lock;
      end
      `SPC_SEL_ALD_OD: begin
        pin_nx = 1'b0;
        oe_nx  = ~ald_s;
      end
      `SPC_SEL_ALD_PP: begin
        pin_nx = ald_s;
        oe_nx  = 1'b1;
      end
      `SPC_SEL_NDIV: begin
        pin_nx = ndiv_s;
        oe_nx  = 1'b1;
      end
      `SPC_SEL_NDIV2: begin
        pin_nx = ndiv_half_reg;
        oe_nx  = 1'b1;
      end
      `SPC_SEL_RDIV: begin
        pin_nx = rdiv_s;
        oe_nx  = 1'b1;
      end
      `SPC_SEL_RDIV2: begin
        pin_nx = rdiv_half_reg;
        oe_nx  = 1'b1;
      end
      `SPC_SEL_UP: begin
        pin_nx = up_s;
        oe_nx  = 1'b1;
      end
      `SPC_SEL_DN: begin
        pin_nx = dn_s;
        oe_nx  = 1'b1;
      end
      default: begin
        pin_nx = 1'b0;
        oe_nx  = 1'b0; // Reserved codes float the pin
      end
    endcase
  end

  // Register the pin so it never glitches on selector changes
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_pin_out <= 1'b0;
      o_pin_oe  <= 1'b0;
    end else begin
      o_pin_out <= pin_nx;
      o_pin_oe  <= oe_nx;
    end
  end

  // Read port: data in the cycle after the strobe, zero otherwise
  // Status bits: [0] lock, [1] pin level, [2] analog lock, [3] bad order
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `SPC_A_CTRL:  o_rdata <= ctrl_reg;
        `SPC_A_MOD:   o_rdata <= mod_reg;
        `SPC_A_STAT:  o_rdata <= {28'h0000000, o_mod_illegal, ald_s,
                                  o_pin_out, o_lock};
        `SPC_A_LDCNT: o_rdata <= {29'h0000000, lock_cnt_reg};
        default:      o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ---- test/spc_chk_asserts.sv ----
// Checker for the synthesizer config bank and test pin
module spc_chk (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire [3:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        o_osc_amp_en,
  input wire [5:0]  o_pump_steps,
  input wire        o_pump_positive,
  input wire        o_pump_high_z,
  input wire        o_ref_double,
  input wire        o_rdiv_bypass,
  input wire [2:0]  o_mod_order,
  input wire        o_mod_enable,
  input wire        o_mod_illegal,
  input wire        o_analog_comp_en,
  input wire        o_dither_en,
  input wire        o_lock,
  input wire        o_pin_out,
  input wire        o_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Field outputs settle two clocks after the write is taken
  wire wc = i_wr && (i_addr == 4'h0);
  wire wm = i_wr && (i_addr == 4'h1);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_pump_gain: assert property (wc |-> ##2
    o_pump_steps == {1'b0, $past(i_wdata[5:1], 2)} + 6'h01)
    else $error("pump step count wrong");
  a_osc_enable: assert property (wc |-> ##2
    o_osc_amp_en == $past(i_wdata[0], 2)) else $error("osc enable wrong");
  a_pump_sense: assert property (wc |-> ##2
    o_pump_positive == $past(i_wdata[10], 2)) else $error("polarity wrong");
  a_ref_double: assert property (wc |-> ##2
    o_ref_double == $past(i_wdata[11], 2) && o_rdiv_bypass == o_ref_double)
    else $error("doubler or bypass wrong");
  a_pump_float: assert property (wc |-> ##2
    o_pump_high_z == $past(i_wdata[12], 2)) else $error("pump float wrong");
  a_order_decode: assert property (wm |-> ##2
    o_mod_illegal == ($past(i_wdata[3:1], 2) > 3'h4) &&
    o_mod_enable == ($past(i_wdata[3:1], 2) inside {[3'h1:3'h4]}))
    else $error("order decode wrong");
  a_first_plain: assert property (o_mod_order == 3'h1 |->
    !o_analog_comp_en && !o_dither_en) else $error("first order extras on");
  // Fixed pin codes: only code 0 floats, code 1 is high, code 2 low
  a_pin_fixed: assert property (wc && i_wdata[9:6] < 4'h3 |-> ##2
    o_pin_oe == ($past(i_wdata[9:6], 2) != 4'h0) &&
    (!o_pin_oe || o_pin_out == ($past(i_wdata[9:6], 2) == 4'h1)))
    else $error("fixed pin level wrong");

  c_lock: cover property ($rose(o_lock));
  c_half: cover property (wc && i_wdata[9:6] == 4'hB);
  c_bad_order: cover property (o_mod_illegal);
endmodule

bind spc_config_test_mux spc_chk u_chk (
  .i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .o_osc_amp_en,
  .o_pump_steps, .o_pump_positive, .o_pump_high_z, .o_ref_double,
  .o_rdiv_bypass, .o_mod_order, .o_mod_enable, .o_mod_illegal,
  .o_analog_comp_en, .o_dither_en, .o_lock, .o_pin_out, .o_pin_oe
);

// ---- test/test_synth_pll_config_and_test_mux.sv ----
// Self-checking bench for the config bank and test pin
module test_synth_pll_config_and_test_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_rst_n, i_wr, i_rd, i_pd_tick, i_in_window;
  logic        i_analog_lock, o_osc_amp_en, o_pump_positive, o_lock;
  logic        o_pump_high_z, o_ref_double, o_rdiv_bypass, o_mod_enable;
  logic        o_mod_illegal, o_analog_comp_en, o_dither_en, o_pin_oe;
  logic        o_wide_n_count, o_pin_out;
  logic [3:0]  i_addr, dg;
  logic [31:0] i_wdata, o_rdata, d, r;
  logic [21:0] i_frac_num, i_frac_den, o_frac_num, o_frac_den;
  logic [5:0]  o_pump_steps;
  logic [2:0]  o_mod_order;
  logic [1:0]  o_dither_level, dt;
  int          mismatches, n_tests, run, b;
  localparam bit [13:0] WSEQ = 14'b11101111110111;

  spc_config_test_mux #(.LOCK_CYCLES(5)) DUT (
    .i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_pd_tick, .i_in_window, .i_analog_lock, .i_ndiv_pulse(dg[0]),
    .i_rdiv_pulse(dg[1]), .i_pd_up(dg[2]), .i_pd_dn(dg[3]), .i_frac_num,
    .i_frac_den, .o_osc_amp_en, .o_pump_steps, .o_pump_positive,
    .o_pump_high_z, .o_ref_double, .o_rdiv_bypass, .o_frac_num, .o_frac_den,
    .o_mod_enable, .o_mod_order, .o_mod_illegal, .o_analog_comp_en,
    .o_dither_en, .o_dither_level, .o_wide_n_count, .o_lock, .o_pin_out,
    .o_pin_oe
  );

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Whole run is under a thousand cycles; this 10000-cycle limit is far beyond it
  initial begin
    #50000;
    mismatches++;
    wrap_up();
  end

  task automatic wrap_up();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  // Strobes drop one edge after rising, so back-to-back calls never clash
  task automatic wr(logic [3:0] a, logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic hold(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Expected pin drive; out is not compared for floating codes 0, E, F or toggling diagnostic codes
  task automatic pin(logic [3:0] s, logic lk, logic al);
    logic [2:0] e;
    case (s)
      4'h0, 4'hE, 4'hF: e = 3'b000;
      4'h1: e = 3'b111;
      4'h2: e = 3'b110;
      4'h3: e = {2'b11, lk};
      4'h4: e = {2'b11, ~lk};
      4'h5: e = {1'b1, ~lk, 1'b0};
      4'h6: e = {1'b1, ~al, 1'b0};
      4'h7: e = {2'b11, al};
      default: e = 3'b010;
    endcase
    chk("pin_oe", e[1], o_pin_oe);
    if (e[2])
      chk("pin_out", e[0], o_pin_out);
  endtask

  initial begin
    {i_wr, i_rd, i_addr, i_wdata, i_pd_tick, i_in_window, dg} = '0;
    {i_analog_lock, i_frac_num, i_frac_den} = '0;
    i_rst_n = 1'b0;
    void'($urandom(64063));
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    hold(3);
    rd(4'h1, r);
    chk("mod_rst", 32'h37, r);
    chk("steps_rst", 6'h01, o_pump_steps);
    pin(4'h0, 1'b0, 1'b0);
    // Random control words; the first sixteen walk every selector code
    for (int i = 0; i < 40; i++) begin
      d = $urandom & 32'h1FFF;
      if (i < 16)
        d[9:6] = i[3:0];
      @(posedge i_clk);
      i_analog_lock <= 1'($urandom);
      wr(4'h0, d);
      rd(4'h0, r);
      chk("ctrl_rb", d, r);
      hold(2);
      chk("osc_en", d[0], o_osc_amp_en);
      chk("steps", d[5:1] + 6'h01, o_pump_steps);
      chk("pol", d[10], o_pump_positive);
      chk("dbl", {d[11], d[11]}, {o_ref_double, o_rdiv_bypass});
      chk("hiz", d[12], o_pump_high_z);
      pin(d[9:6], 1'b0, i_analog_lock);
    end
    wr(4'h9, 32'h1FFF);
    rd(4'h0, r);
    chk("unmapped_wr", d, r);
    rd(4'h7, r);
    chk("unmapped_rd", 32'h0, r);
    // Diagnostic routes: plain ones follow the pulse, halved ones toggle
    for (int c = 8; c < 14; c++) begin
      b = (c < 12) ? (c - 8) / 2 : c - 10;
      wr(4'h0, c << 6);
      hold(4);
      d = o_pin_out;
      @(posedge i_clk);
      dg[b] <= 1'b1;
      hold(6);
      chk("diag_hi", c % 2 && c < 12 ? !d[0] : 1'b1, o_pin_out);
      @(posedge i_clk);
      dg[b] <= 1'b0;
      hold(6);
      chk("diag_lo", c % 2 && c < 12 ? !d[0] : 1'b0, o_pin_out);
    end
    // Lock needs five in-window ticks in a row; one miss restarts it
    wr(4'h0, 32'h3 << 6);
    run = 0;
    for (int i = 13; i >= 0; i--) begin
      @(posedge i_clk);
      i_in_window <= WSEQ[i];
      i_pd_tick <= 1'b1;
      hold(4);
      @(posedge i_clk);
      i_pd_tick <= 1'b0;
      hold(5);
      run = WSEQ[i] ? run + 1 : 0;
      chk("lock", run >= 5, o_lock);
      pin(4'h3, run >= 5, 1'b0);
      rd(4'h2, r);
      chk("stat_lock", run >= 5, r[0]);
      chk("stat_pin", run >= 5, r[1]);
    end
    // Every order; all dither codes from second order up, code 3 (off) below it
    for (int o = 0; o < 8; o++) begin
      for (int t = 0; t < 4; t++) begin
        dt = (o < 2) ? 2'h3 : t[1:0];
        d = {26'h0, dt, o[2:0], 1'($urandom)};
        // Narrow fraction corner, as a shift keying setup needs
        if (t == 0)
          d[0] = 1'b0;
        @(posedge i_clk);
        i_frac_num <= 22'($urandom) | 22'h1;
        i_frac_den <= 22'($urandom);
        wr(4'h1, d);
        rd(4'h1, r);
        chk("mod_rb", d, r);
        hold(2);
        chk("illegal", o > 4, o_mod_illegal);
        chk("enable", o inside {[1:4]}, o_mod_enable);
        chk("order", o > 4 ? 0 : o, o_mod_order);
        chk("wide_n", o == 0 || o > 4, o_wide_n_count);
        chk("comp", o inside {[2:4]}, o_analog_comp_en);
        chk("dither_strength_en", o inside {[2:4]} && dt != 3, o_dither_en);
        chk("dither_strength_lvl", dt, o_dither_level);
        chk("frac_n", d[0] ? i_frac_num : i_frac_num[9:0], o_frac_num);
        chk("frac_d", d[0] ? i_frac_den : i_frac_den[9:0], o_frac_den);
      end
    end
    wrap_up();
  end
endmodule
